// >>> rtl/sync_serial_pkg.sv
// Shared constants of the synchronous serial status and interrupt block.
// Assumes a 32-bit APB master; each register index times four is its byte address.
// Functional notes
// - Transmit runs only while tx_enable is 1
// - Receive runs only while rx_enable is 1
// - Transmit-done request gated by its enable
// - Transmit-empty request gated by its enable
// - One receive enable gates full and overrun
// - Collision request gated by its enable
// - Overrun set on reception while buffer full
// - Overrun keeps old byte, drops new one
// - Overrun flag blocks further reception
// - As master, overrun also blocks transmission
// - Done set on last bit with empty; write clears
// - Empty set while disabled or on load
// - Writing transmit data clears empty flag while transmit is enabled
// - Full set when received byte is stored
// - Reading receive data clears full flag
// - Master select-pin start with pin low: collision
// - Slave select-pin rise mid-transfer: collision
// - Flags cleared by writing 0 after reading 1
// - Receive path is double buffered
// - Idle shifter loads transmit data, back to back
package sync_serial_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] MODE_IDX = 16'hf0e1;
  localparam logic [15:0] ENABLE_IDX = 16'hf0e3;
  localparam logic [15:0] FLAG_IDX = 16'hf0e4;
  localparam logic [15:0] RX_DATA_IDX = 16'hf0e9;
  localparam logic [15:0] TX_DATA_IDX = 16'hf0eb;

  // Enable register fields
  localparam int TX_ENABLE_BIT = 7;
  localparam int RX_ENABLE_BIT = 6;
  localparam int TX_DONE_IRQ_EN_BIT = 3;
  localparam int TX_EMPTY_IRQ_EN_BIT = 2;
  localparam int RX_IRQ_EN_BIT = 1;
  localparam int COLLISION_IRQ_EN_BIT = 0;

  // Flag register fields
  localparam int OVERRUN_BIT = 6;
  localparam int TX_DONE_BIT = 3;
  localparam int TX_EMPTY_BIT = 2;
  localparam int RX_FULL_BIT = 1;
  localparam int COLLISION_BIT = 0;

  // Mode register fields
  localparam int MASTER_SEL_BIT = 0;
  localparam int SELECT_PIN_MODE_BIT = 1;

  // Reset values
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic TX_EMPTY_RESET = 1'b1;

endpackage

// >>> rtl/sync_serial_status_irq.sv
// Status flags, enables, data registers and interrupt requests of a synchronous serial unit.
// Assumes an external shift engine that reports idle, last bit and byte-received events,
// a synchronous chip-select input and a zero-wait APB master.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module sync_serial_status_irq
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Shift engine
  input wire logic shift_idle_in,
  input wire logic xfer_busy_in,
  input wire logic tx_last_bit_in,
  input wire logic rx_done_in,
  input wire logic [7:0] rx_byte_in,
  output logic tx_load_out,
  output logic [7:0] tx_byte_out,
  output logic tx_run_out,
  output logic rx_run_out,
  output logic master_sel_out,
  output logic select_pin_mode_out,
  // Peer select pin
  input wire logic chip_select_pin_in,
  // Interrupt requests
  output logic tx_done_irq_out,
  output logic tx_empty_irq_out,
  output logic rx_full_irq_out,
  output logic overrun_irq_out,
  output logic collision_irq_out
);

  // Matches a bus address against a register index
  function automatic logic addr_hit(input logic [31:0] addr, input logic [15:0] idx);
    addr_hit = (addr == {14'h0000, idx, 2'b00});
  endfunction

  // Software register state
  logic [7:0] irq_enable_reg_ff; // Enables
  logic [1:0] mode_reg_ff; // Master select and select-pin mode
  logic [7:0] tx_data_reg_ff; // Byte waiting for the shifter
  logic [7:0] rx_data_reg_ff; // Last stored received byte
  logic [31:0] prdata_ff; // Read data captured in setup phase
  logic load_ff; // Registered load strobe
  logic [7:0] load_byte_ff; // Byte handed to the shifter
  logic cs_prev_ff; // Select pin one cycle ago

  // Flag state
  logic overrun_flag_ff;
  logic tx_done_flag_ff;
  logic tx_buf_empty_flag_ff;
  logic rx_buf_full_flag_ff;
  logic collision_flag_ff;
  logic [7:0] arm_ff; // Flags seen as 1 by software since last clear

  // Bus decode
  logic setup_ph;
  logic access_ph;
  logic hit_mode;
  logic hit_enable;
  logic hit_flag;
  logic hit_rx;
  logic hit_tx;
  logic mapped;
  logic wr_enable;
  logic wr_mode;
  logic wr_flag;
  logic wr_tx;
  logic rd_rx;
  logic rd_flag;

  // Enable fields
  logic tx_enable;
  logic rx_enable;
  logic tx_done_irq_en;
  logic tx_empty_irq_en;
  logic rx_irq_en;
  logic collision_irq_en;
  logic master_sel;
  logic select_pin_mode;

  // Engine events
  logic start_try; // Idle shifter with a byte to send
  logic start_ok;
  logic start_collide;
  logic rx_take; // Reception counted while enabled
  logic slave_collide;
  logic [7:0] flag_vec; // Flag register image

  assign setup_ph = psel_in && !penable_in;
  assign access_ph = psel_in && penable_in;
  assign hit_mode = addr_hit(paddr_in, sync_serial_pkg::MODE_IDX);
  assign hit_enable = addr_hit(paddr_in, sync_serial_pkg::ENABLE_IDX);
  assign hit_flag = addr_hit(paddr_in, sync_serial_pkg::FLAG_IDX);
  assign hit_rx = addr_hit(paddr_in, sync_serial_pkg::RX_DATA_IDX);
  assign hit_tx = addr_hit(paddr_in, sync_serial_pkg::TX_DATA_IDX);
  assign mapped = hit_mode || hit_enable || hit_flag || hit_rx || hit_tx;
  assign wr_enable = access_ph && pwrite_in && hit_enable;
  assign wr_mode = access_ph && pwrite_in && hit_mode;
  assign wr_flag = access_ph && pwrite_in && hit_flag;
  assign wr_tx = access_ph && pwrite_in && hit_tx;
  assign rd_rx = access_ph && !pwrite_in && hit_rx;
  assign rd_flag = access_ph && !pwrite_in && hit_flag;

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready_out = 1'b1;
  assign pslverr_out = access_ph && !mapped;
  assign prdata_out = prdata_ff;

  assign tx_enable = irq_enable_reg_ff[sync_serial_pkg::TX_ENABLE_BIT];
  assign rx_enable = irq_enable_reg_ff[sync_serial_pkg::RX_ENABLE_BIT];
  assign tx_done_irq_en = irq_enable_reg_ff[sync_serial_pkg::TX_DONE_IRQ_EN_BIT];
  assign tx_empty_irq_en = irq_enable_reg_ff[sync_serial_pkg::TX_EMPTY_IRQ_EN_BIT];
  assign rx_irq_en = irq_enable_reg_ff[sync_serial_pkg::RX_IRQ_EN_BIT];
  assign collision_irq_en = irq_enable_reg_ff[sync_serial_pkg::COLLISION_IRQ_EN_BIT];
  assign master_sel = mode_reg_ff[sync_serial_pkg::MASTER_SEL_BIT];
  assign select_pin_mode = mode_reg_ff[sync_serial_pkg::SELECT_PIN_MODE_BIT];

  // Flag register image; unused bits read as zero
  always_comb
  begin
    flag_vec = 8'h00;
    flag_vec[sync_serial_pkg::OVERRUN_BIT] = overrun_flag_ff;
    flag_vec[sync_serial_pkg::TX_DONE_BIT] = tx_done_flag_ff;
    flag_vec[sync_serial_pkg::TX_EMPTY_BIT] = tx_buf_empty_flag_ff;
    flag_vec[sync_serial_pkg::RX_FULL_BIT] = rx_buf_full_flag_ff;
    flag_vec[sync_serial_pkg::COLLISION_BIT] = collision_flag_ff;
  end

  // Software clear: write 0 to a bit previously read as 1
  function automatic logic sw_clear(input logic wr, input logic [7:0] wdata, input logic [7:0] arm, input int b);
    sw_clear = wr && !wdata[b] && arm[b];
  endfunction

  // Start only when the shifter is idle and data is waiting
  assign start_try = shift_idle_in && tx_enable && !tx_buf_empty_flag_ff && !load_ff;
  // A master with an overrun holds transmission off
  assign start_collide = start_try && select_pin_mode && master_sel && !chip_select_pin_in;
  assign start_ok = start_try && !start_collide && !(master_sel && overrun_flag_ff);
  // Receptions are ignored while disabled or overrun
  assign rx_take = rx_done_in && rx_enable && !overrun_flag_ff;
  // Slave sees the select pin rise during a transfer
  assign slave_collide = select_pin_mode && !master_sel && xfer_busy_in && !cs_prev_ff && chip_select_pin_in;

  assign tx_run_out = tx_enable && !(master_sel && overrun_flag_ff);
  assign rx_run_out = rx_enable && !overrun_flag_ff;
  assign tx_load_out = load_ff;
  assign tx_byte_out = load_byte_ff;
  assign master_sel_out = master_sel;
  assign select_pin_mode_out = select_pin_mode;

  // Requests follow flag AND enable, so they stay up until the flag clears
  assign tx_done_irq_out = tx_done_flag_ff && tx_done_irq_en;
  assign tx_empty_irq_out = tx_buf_empty_flag_ff && tx_empty_irq_en;
  assign rx_full_irq_out = rx_buf_full_flag_ff && rx_irq_en;
  assign overrun_irq_out = overrun_flag_ff && rx_irq_en;
  assign collision_irq_out = collision_flag_ff && collision_irq_en;

  // Read data is captured in the setup phase so the arm bits match what software saw
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      prdata_ff <= 32'h0000_0000;
    end
    else if (setup_ph && !pwrite_in)
    begin
      if (hit_enable)
      begin
        prdata_ff <= {24'h00_0000, irq_enable_reg_ff};
      end
      else if (hit_mode)
      begin
        prdata_ff <= {30'h0000_0000, mode_reg_ff};
      end
      else if (hit_flag)
      begin
        prdata_ff <= {24'h00_0000, flag_vec};
      end
      else if (hit_rx)
      begin
        prdata_ff <= {24'h00_0000, rx_data_reg_ff};
      end
      else if (hit_tx)
      begin
        prdata_ff <= {24'h00_0000, tx_data_reg_ff};
      end
      else
      begin
        // Unmapped reads return zero
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // Enable and mode registers
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      irq_enable_reg_ff <= sync_serial_pkg::ENABLE_RESET;
      mode_reg_ff <= sync_serial_pkg::MODE_RESET;
    end
    else
    begin
      if (wr_enable)
      begin
        irq_enable_reg_ff <= pwdata_in[7:0];
      end
      if (wr_mode)
      begin
        mode_reg_ff <= pwdata_in[1:0];
      end
    end
  end

  // Transmit data register and the load strobe to the shifter
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tx_data_reg_ff <= sync_serial_pkg::DATA_RESET;
      load_ff <= 1'b0;
      load_byte_ff <= sync_serial_pkg::DATA_RESET;
    end
    else
    begin
      load_ff <= start_ok;
      if (start_ok)
      begin
        load_byte_ff <= tx_data_reg_ff;
      end
      if (wr_tx)
      begin
        tx_data_reg_ff <= pwdata_in[7:0];
      end
    end
  end

  // Receive data register; the shifter is free once its byte is stored
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rx_data_reg_ff <= sync_serial_pkg::DATA_RESET;
    end
    else if (rx_take && !rx_buf_full_flag_ff)
    begin
      // A byte arriving while full is dropped, the old one kept
      rx_data_reg_ff <= rx_byte_in;
    end
  end

  // Select pin history for the edge check
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cs_prev_ff <= 1'b1;
    end
    else
    begin
      cs_prev_ff <= chip_select_pin_in;
    end
  end

  // Arm bits: a flag read as 1 may then be cleared by writing 0
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      arm_ff <= 8'h00;
    end
    else if (rd_flag)
    begin
      arm_ff <= prdata_ff[7:0];
    end
    else if (wr_flag)
    begin
      // Any bit written as 0 is disarmed; bits written as 1 stay armed
      arm_ff <= arm_ff & pwdata_in[7:0];
    end
  end

  // Overrun flag; set wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      overrun_flag_ff <= sync_serial_pkg::FLAG_RESET;
    end
    else if (rx_take && rx_buf_full_flag_ff)
    begin
      overrun_flag_ff <= 1'b1;
    end
    else if (sw_clear(wr_flag, pwdata_in[7:0], arm_ff, sync_serial_pkg::OVERRUN_BIT))
    begin
      overrun_flag_ff <= 1'b0;
    end
  end

  // Transmit-done flag; a data write also clears it
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tx_done_flag_ff <= sync_serial_pkg::FLAG_RESET;
    end
    else if (tx_last_bit_in && tx_buf_empty_flag_ff)
    begin
      tx_done_flag_ff <= 1'b1;
    end
    else if (wr_tx || sw_clear(wr_flag, pwdata_in[7:0], arm_ff, sync_serial_pkg::TX_DONE_BIT))
    begin
      tx_done_flag_ff <= 1'b0;
    end
  end

  // Transmit-empty flag; held at 1 while transmit is disabled
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tx_buf_empty_flag_ff <= sync_serial_pkg::TX_EMPTY_RESET;
    end
    else if (!tx_enable || start_ok)
    begin
      tx_buf_empty_flag_ff <= 1'b1;
    end
    else if (wr_tx || sw_clear(wr_flag, pwdata_in[7:0], arm_ff, sync_serial_pkg::TX_EMPTY_BIT))
    begin
      tx_buf_empty_flag_ff <= 1'b0;
    end
  end

  // Receive-full flag; a read of the receive data clears it
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rx_buf_full_flag_ff <= sync_serial_pkg::FLAG_RESET;
    end
    else if (rx_take && !rx_buf_full_flag_ff)
    begin
      rx_buf_full_flag_ff <= 1'b1;
    end
    else if (rd_rx || sw_clear(wr_flag, pwdata_in[7:0], arm_ff, sync_serial_pkg::RX_FULL_BIT))
    begin
      rx_buf_full_flag_ff <= 1'b0;
    end
  end

  // Collision flag from either master start or slave select edge
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      collision_flag_ff <= sync_serial_pkg::FLAG_RESET;
    end
    else if (start_collide || slave_collide)
    begin
      collision_flag_ff <= 1'b1;
    end
    else if (sw_clear(wr_flag, pwdata_in[7:0], arm_ff, sync_serial_pkg::COLLISION_BIT))
    begin
      collision_flag_ff <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> test/sync_serial_asserts.sv
// Port-level checker for the serial status and interrupt block.
// Assumes it is bound into sync_serial_status_irq and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module sync_serial_asserts
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic tx_load_out,
  input wire logic [7:0] tx_byte_out,
  input wire logic shift_idle_in,
  input wire logic tx_run_out,
  input wire logic rx_run_out,
  input wire logic master_sel_out,
  input wire logic select_pin_mode_out,
  input wire logic chip_select_pin_in,
  input wire logic tx_last_bit_in,
  input wire logic rx_done_in,
  input wire logic overrun_irq_out,
  input wire logic tx_done_irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // Load pulse must end after one cycle, so loads sit at least two cycles apart
  sequence pulse_end_s;
    !tx_load_out;
  endsequence

  load_pulse_a: assert property (tx_load_out |=> pulse_end_s)
    else $error("load pulse too long");
  load_cause_a: assert property (tx_load_out |-> $past(tx_run_out && shift_idle_in))
    else $error("load without enable or idle shifter");
  load_clash_a: assert property (tx_load_out |->
    !$past(select_pin_mode_out && master_sel_out && !chip_select_pin_in))
    else $error("load despite low select pin");
  byte_hold_a: assert property (!tx_load_out |-> $stable(tx_byte_out))
    else $error("shift byte changed without load");
  ovr_rx_a: assert property (overrun_irq_out |-> !rx_run_out)
    else $error("receive runs during overrun");
  ovr_tx_a: assert property (overrun_irq_out && master_sel_out |-> !tx_run_out)
    else $error("master transmits during overrun");
  ovr_cause_a: assert property ($rose(overrun_irq_out) |->
    $past(rx_done_in) || $past(psel_in && penable_in && pwrite_in))
    else $error("overrun request without cause");
  done_cause_a: assert property ($rose(tx_done_irq_out) |->
    $past(tx_last_bit_in) || $past(psel_in && penable_in && pwrite_in))
    else $error("done request without cause");
endmodule

bind sync_serial_status_irq sync_serial_asserts sync_serial_asserts_inst (.clk_in, .rst_b_in,
  .psel_in, .penable_in, .pwrite_in, .tx_load_out, .tx_byte_out, .shift_idle_in, .tx_run_out,
  .rx_run_out, .master_sel_out, .select_pin_mode_out, .chip_select_pin_in, .tx_last_bit_in,
  .rx_done_in, .overrun_irq_out, .tx_done_irq_out);

`default_nettype wire

// >>> test/serial_peer_model.sv
// Behavioural shift engine and serial peer facing the status block.
// Assumes the block pulses tx_load_in for one cycle per byte.
`timescale 1ns/100ps
`default_nettype none

module serial_peer_model
(
  input wire logic clk_in,
  input wire logic tx_load_in,
  input wire logic [7:0] tx_byte_in,
  output logic shift_idle_out,
  output logic xfer_busy_out,
  output logic tx_last_bit_out,
  output logic rx_done_out,
  output logic [7:0] rx_byte_out
);
  logic [3:0] bit_cnt; // Bits left in frame
  logic [7:0] last_byte; // Byte last taken
  int loads = 0; // Frames taken

  // Idle shifter at start, no events pending
  initial
  begin
    shift_idle_out = 1'b1;
    xfer_busy_out = 1'b0;
    tx_last_bit_out = 1'b0;
    rx_done_out = 1'b0;
    rx_byte_out = 8'h00;
    bit_cnt = 4'h0;
  end

  // Eight-bit frame; idle drops at once so no second load lands
  always @(posedge clk_in)
  begin
    tx_last_bit_out <= 1'b0;
    if (tx_load_in)
    begin
      shift_idle_out <= 1'b0;
      xfer_busy_out <= 1'b1;
      bit_cnt <= 4'h8;
      last_byte <= tx_byte_in;
      loads <= loads + 1;
    end
    else if (bit_cnt != 4'h0)
    begin
      bit_cnt <= bit_cnt - 4'h1;
      if (bit_cnt == 4'h1)
      begin
        tx_last_bit_out <= 1'b1;
        shift_idle_out <= 1'b1;
        xfer_busy_out <= 1'b0;
      end
    end
  end

  // One received byte; the bus then shows the inverse, not stale data
  task automatic send_rx(input logic [7:0] b);
    @(posedge clk_in);
    rx_done_out <= 1'b1;
    rx_byte_out <= b;
    @(posedge clk_in);
    rx_done_out <= 1'b0;
    rx_byte_out <= ~b;
  endtask
endmodule

`default_nettype wire

// >>> test/sync_serial_status_irq_tb_top.sv
// Self-checking bench for the serial status and interrupt block.
// Assumes the peer model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", nm, e, s); end end

module sync_serial_status_irq_tb_top;
  localparam logic [15:0] EN = sync_serial_pkg::ENABLE_IDX;
  localparam logic [15:0] FL = sync_serial_pkg::FLAG_IDX;
  localparam logic [15:0] RX = sync_serial_pkg::RX_DATA_IDX;
  localparam logic [15:0] TX = sync_serial_pkg::TX_DATA_IDX;
  localparam logic [15:0] MD = sync_serial_pkg::MODE_IDX;
  logic clk_in, rst_b_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [31:0] paddr_in, pwdata_in, prdata_out, exp_v;
  logic shift_idle_in, xfer_busy_in, tx_last_bit_in, rx_done_in, chip_select_pin_in;
  logic [7:0] rx_byte_in, tx_byte_out, en;
  logic tx_load_out, tx_run_out, rx_run_out, master_sel_out, select_pin_mode_out;
  logic tx_done_irq_out, tx_empty_irq_out, rx_full_irq_out, overrun_irq_out, collision_irq_out;
  logic [31:0] expq[$]; // Expected read data, oldest first
  int fails = 0, n_checks = 0, seed = 75, n, i, r;

  sync_serial_status_irq sync_serial_status_irq_inst (.clk_in, .rst_b_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .shift_idle_in, .xfer_busy_in, .tx_last_bit_in, .rx_done_in, .rx_byte_in, .tx_load_out,
    .tx_byte_out, .tx_run_out, .rx_run_out, .master_sel_out, .select_pin_mode_out,
    .chip_select_pin_in, .tx_done_irq_out, .tx_empty_irq_out, .rx_full_irq_out,
    .overrun_irq_out, .collision_irq_out);

  serial_peer_model serial_peer_model_inst (.clk_in, .tx_load_in(tx_load_out),
    .tx_byte_in(tx_byte_out), .shift_idle_out(shift_idle_in), .xfer_busy_out(xfer_busy_in),
    .tx_last_bit_out(tx_last_bit_in), .rx_done_out(rx_done_in), .rx_byte_out(rx_byte_in));

  // 10 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic tally_and_finish();
    if (fails == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int k;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= {14'h0000, idx, 2'h0};
    pwdata_in <= {24'h00_0000, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk_in);
      if (pready_out === 1'b1)
        break;
    end
    if (k == 20)
    begin
      fails++;
      tally_and_finish();
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  // Note the expected word, then read
  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    expq.push_back({24'h00_0000, e});
    apb(1'b0, idx, 8'h00);
  endtask

  // Takes the oldest note whenever read data is taken
  always @(posedge clk_in)
  begin
    if (psel_in && penable_in && !pwrite_in && pready_out)
    begin
      exp_v = expq.pop_front();
      `CHK("prdata", exp_v, prdata_out)
      `CHK("pslverr", (paddr_in == 32'h0000_0000), pslverr_out)
    end
  end

  initial
  begin
    rst_b_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 32'h0000_0000;
    pwdata_in = 32'h0000_0000;
    chip_select_pin_in = 1'b1;
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(EN, 8'h00);
    rd(FL, 8'h04);
    rd(RX, 8'h00);
    // Master with select pin low: start refused
    wr(MD, 8'h03);
    wr(EN, 8'hcf);
    chip_select_pin_in <= 1'b0;
    wr(TX, 8'h5a);
    repeat (4) @(posedge clk_in);
    `CHK("loads", 0, serial_peer_model_inst.loads)
    rd(FL, 8'h01);
    chip_select_pin_in <= 1'b1;
    for (n = 0; n < 60 && tx_done_irq_out !== 1'b1; n++)
      @(posedge clk_in);
    if (n == 60)
    begin
      fails++;
      tally_and_finish();
    end
    `CHK("tx byte", 8'h5a, serial_peer_model_inst.last_byte)
    rd(FL, 8'h0d);
    serial_peer_model_inst.send_rx(8'h3c);
    rd(FL, 8'h0f);
    // Random enable patterns against four raised flags
    for (i = 0; i < 8; i++)
    begin
      r = $random(seed);
      en = {4'hc, r[3:0]};
      // Pin wiggles are harmless here: master with nothing to send
      chip_select_pin_in <= r[4];
      wr(EN, en);
      @(posedge clk_in);
      `CHK("done irq", en[3], tx_done_irq_out)
      `CHK("empty irq", en[2], tx_empty_irq_out)
      `CHK("full irq", en[1], rx_full_irq_out)
      `CHK("clash irq", en[0], collision_irq_out)
    end
    chip_select_pin_in <= 1'b1;
    wr(EN, 8'hcf);
    rd(FL, 8'h0f);
    wr(FL, 8'hff);
    rd(FL, 8'h0f);
    wr(FL, 8'hf4);
    rd(FL, 8'h04);
    // Overrun as master
    wr(MD, 8'h01);
    serial_peer_model_inst.send_rx(8'h11);
    rd(RX, 8'h11);
    rd(FL, 8'h04);
    serial_peer_model_inst.send_rx(8'h22);
    serial_peer_model_inst.send_rx(8'h33);
    serial_peer_model_inst.send_rx(8'h44);
    rd(FL, 8'h46);
    `CHK("ovr irq", 1'b1, overrun_irq_out)
    `CHK("tx run", 1'b0, tx_run_out)
    `CHK("rx run", 1'b0, rx_run_out)
    rd(RX, 8'h22);
    wr(FL, 8'hbf);
    rd(FL, 8'h04);
    `CHK("rx run", 1'b1, rx_run_out)
    // Both directions disabled
    wr(EN, 8'h00);
    @(posedge clk_in);
    `CHK("tx run", 1'b0, tx_run_out)
    `CHK("rx run", 1'b0, rx_run_out)
    serial_peer_model_inst.send_rx(8'h77);
    rd(RX, 8'h22);
    wr(TX, 8'h99);
    rd(FL, 8'h04);
    // Slave in select-pin mode: pin rises while the frame runs
    wr(MD, 8'h02);
    wr(EN, 8'hcf);
    chip_select_pin_in <= 1'b0;
    wr(TX, 8'h66);
    repeat (3) @(posedge clk_in);
    chip_select_pin_in <= 1'b1;
    @(posedge clk_in);
    rd(FL, 8'h05);
    `CHK("clash irq", 1'b1, collision_irq_out)
    rd(16'h0000, 8'h00);
    tally_and_finish();
  end
endmodule

`default_nettype wire
